// >>> inc/sub_exec_defs.svh
`ifndef SUB_EXEC_DEFS_SVH
`define SUB_EXEC_DEFS_SVH
// APB register byte offsets.
`define SX_OFF_CTRL 12'h000
`define SX_OFF_INSTR 12'h004
`define SX_OFF_WREG 12'h008
`define SX_OFF_BANK 12'h00C
`define SX_OFF_STATUS 12'h010
`define SX_OFF_FADDR 12'h014
`define SX_OFF_FSR2 12'h018
`define SX_OFF_MEM 12'h400
// Opcode patterns.
`define SX_OP_SUB_LIT 8'h08
`define SX_OP_SUB_FILE 6'h17
// Access bank split and indexed literal offset limit.
`define SX_ACC_LOW_MAX 8'h7F
`define SX_ILO_MAX 8'h5F
// Status field positions.
`define SX_ST_C 0
`define SX_ST_DIGIT_CARRY 1
`define SX_ST_Z 2
`define SX_ST_OVERFLOW 3
`define SX_ST_N 4
// Control bit positions; bank and W reset values.
`define SX_CTRL_EXT 0
`define SX_CTRL_GO 1
`define SX_BANK_RST 4'h0
`define SX_W_RST 8'h00
`endif

// >>> inc/sx_pkg.sv
package sx_pkg;
	typedef enum logic [1:0] {SX_IDLE, SX_READ, SX_EXEC, SX_WRITE} sx_state_t;
	typedef logic [7:0] sx_byte_t;
endpackage

// >>> verilog/sx_alu.sv
`include "sub_exec_defs.svh"
// Eight-bit subtractor producing minuend minus subtrahend with all five flags.
module sx_alu (
	input wire sx_pkg::sx_byte_t minu,
	input wire sx_pkg::sx_byte_t subt,
	output sx_pkg::sx_byte_t res,
	output logic [4:0] flags
);
	import sx_pkg::*;
	logic [8:0] full;
	logic [4:0] low;
	// Two's complement add of the inverted subtrahend; carry is the inverse of borrow.
	always_comb begin
		full = {1'b0, minu} + {1'b0, ~subt} + 9'h001;
		low = {1'b0, minu[3:0]} + {1'b0, ~subt[3:0]} + 5'h01;
		res = full[7:0];
		flags = 5'h00;
		flags[`SX_ST_C] = full[8];
		flags[`SX_ST_DIGIT_CARRY] = low[4];
		flags[`SX_ST_Z] = (full[7:0] == 8'h00);
		flags[`SX_ST_OVERFLOW] = (minu[7] != subt[7]) && (full[7] != minu[7]);
		flags[`SX_ST_N] = full[7];
	end
endmodule

// >>> verilog/sx_core.sv
// Our own choices: the APB interface to the registers and the address map.
`include "sub_exec_defs.svh"
module sx_core #(
	parameter int MEM_DEPTH = 4096
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy
);
	import sx_pkg::*;
	// Data memory; the window and the executing instruction share it.
	logic [7:0] mem [0:MEM_DEPTH-1];

	// Software-visible registers and their next values.
	logic [15:0] instr_r;
	logic [15:0] instr_nxt;
	logic [7:0] w_r;
	logic [7:0] w_nxt;
	logic [3:0] bank_r;
	logic [3:0] bank_nxt;
	logic [4:0] st_r;
	logic [4:0] st_nxt;
	logic [11:0] faddr_r;
	logic [11:0] faddr_nxt;
	logic [11:0] fsr2_r;
	logic [11:0] fsr2_nxt;
	logic ext_r;
	logic ext_nxt;

	// Execution sequencing and the latched file operand.
	sx_state_t state_r;
	sx_state_t state_nxt;
	logic [7:0] opnd_r;
	logic [7:0] opnd_nxt;

	// Memory ports.
	logic [7:0] rd_mem_r;
	logic mem_we;
	logic [11:0] mem_wa;
	logic [7:0] mem_wd;
	logic [11:0] win_addr;

	// Decode and datapath wires.
	logic [11:0] ea;
	logic is_lit;
	logic is_file;
	logic [7:0] alu_res;
	logic [4:0] alu_flags;
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] fbyte;

	// Decode the two supported opcodes.
	assign is_lit = (instr_r[15:8] == `SX_OP_SUB_LIT);
	assign is_file = (instr_r[15:10] == `SX_OP_SUB_FILE);
	assign acc = instr_r[8];
	assign fbyte = instr_r[7:0];

	// Bus strobes; the slave never inserts wait states.
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign busy = (state_r != SX_IDLE);

	// Memory window address: the window base plus the offset into the window.
	assign win_addr = paddr - `SX_OFF_MEM + faddr_r;

	// Effective file address from access bit, bank select and extended mode.
	always_comb begin
		if (!acc && ext_r && (fbyte <= `SX_ILO_MAX)) begin
			ea = fsr2_r + {4'h0, fbyte};
		end else if (!acc) begin
			ea = (fbyte <= `SX_ACC_LOW_MAX) ? {4'h0, fbyte} : {4'hF, fbyte};
		end else begin
			ea = {bank_r, fbyte};
		end
	end

	// Subtractor; the literal form replaces the file operand by the literal.
	sx_alu u_alu (
		.minu(is_lit ? fbyte : opnd_r),
		.subt(w_r),
		.res(alu_res),
		.flags(alu_flags)
	);

	// Register file, execution sequencing and memory write.
	always_comb begin
		instr_nxt = instr_r;
		w_nxt = w_r;
		bank_nxt = bank_r;
		st_nxt = st_r;
		faddr_nxt = faddr_r;
		fsr2_nxt = fsr2_r;
		ext_nxt = ext_r;
		state_nxt = state_r;
		opnd_nxt = opnd_r;
		mem_we = 1'b0;
		mem_wa = faddr_r;
		mem_wd = pwdata[7:0];
		pslverr = 1'b0;
		if (wr) begin
			if (paddr >= `SX_OFF_MEM) begin
				mem_we = 1'b1;
				mem_wa = win_addr;
			end else begin
				case (paddr)
					`SX_OFF_CTRL: begin
						ext_nxt = pwdata[`SX_CTRL_EXT];
						if (pwdata[`SX_CTRL_GO] && state_r == SX_IDLE) begin
							state_nxt = SX_READ;
						end
					end
					`SX_OFF_INSTR: instr_nxt = pwdata[15:0];
					`SX_OFF_WREG: w_nxt = pwdata[7:0];
					`SX_OFF_BANK: bank_nxt = pwdata[3:0];
					`SX_OFF_STATUS: st_nxt = pwdata[4:0];
					`SX_OFF_FADDR: faddr_nxt = pwdata[11:0];
					`SX_OFF_FSR2: fsr2_nxt = pwdata[11:0];
					default: pslverr = 1'b1;
				endcase
			end
		end

		// Sequencer: fetch the operand, then execute and write back.
		case (state_r)
			SX_IDLE: state_nxt = state_nxt;
			SX_READ: begin
				opnd_nxt = mem[ea];
				state_nxt = (is_lit || is_file) ? SX_EXEC : SX_IDLE;
			end
			SX_EXEC: begin
				st_nxt = alu_flags;
				if (is_lit || !instr_r[9]) begin
					w_nxt = alu_res;
				end else begin
					mem_we = 1'b1;
					mem_wa = ea;
					mem_wd = alu_res;
				end
				state_nxt = SX_IDLE;
			end
			default: state_nxt = SX_IDLE;
		endcase

		// Read decode raises the slave error for unmapped offsets.
		if (rd && !(paddr >= `SX_OFF_MEM)) begin
			case (paddr)
				`SX_OFF_CTRL, `SX_OFF_INSTR, `SX_OFF_WREG, `SX_OFF_BANK,
				`SX_OFF_STATUS, `SX_OFF_FADDR, `SX_OFF_FSR2: pslverr = 1'b0;
				default: pslverr = 1'b1;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_r <= 16'h0000;
			w_r <= `SX_W_RST;
			bank_r <= `SX_BANK_RST;
			st_r <= 5'h00;
			faddr_r <= 12'h000;
			fsr2_r <= 12'h000;
			ext_r <= 1'b0;
			state_r <= SX_IDLE;
			opnd_r <= 8'h00;
		end else begin
			instr_r <= instr_nxt;
			w_r <= w_nxt;
			bank_r <= bank_nxt;
			st_r <= st_nxt;
			faddr_r <= faddr_nxt;
			fsr2_r <= fsr2_nxt;
			ext_r <= ext_nxt;
			state_r <= state_nxt;
			opnd_r <= opnd_nxt;
		end
	end

	// Data memory write port and read sampling.
	always_ff @(posedge pclk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		rd_mem_r <= mem[win_addr];
	end

	// Read data mux, combinational from registered state.
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			`SX_OFF_CTRL: prdata = {30'h0, busy, ext_r};
			`SX_OFF_INSTR: prdata = {16'h0000, instr_r};
			`SX_OFF_WREG: prdata = {24'h00_0000, w_r};
			`SX_OFF_BANK: prdata = {28'h000_0000, bank_r};
			`SX_OFF_STATUS: prdata = {27'h000_0000, st_r};
			`SX_OFF_FADDR: prdata = {20'h0_0000, faddr_r};
			`SX_OFF_FSR2: prdata = {20'h0_0000, fsr2_r};
			default: begin
				if (paddr >= `SX_OFF_MEM) begin
					prdata = {24'h00_0000, rd_mem_r};
				end
			end
		endcase
	end
endmodule

// >>> verif/sx_core_properties.sv
module sx_core_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic busy
);
	logic rd;
	// Flags a read access phase.
	assign rd = psel && penable && !pwrite;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// A start request taken while idle.
	sequence go_s;
		psel && penable && pwrite && paddr == 12'h000 && pwdata[1] && !busy;
	endsequence
	// Two busy cycles, then idle.
	sequence run_s;
		busy [*2] ##1 !busy;
	endsequence
	ready_access_a: assert property (psel && penable |-> pready) else $error("no ready");
	go_run_a: assert property (go_s |=> run_s) else $error("busy length");
	busy_cause_a: assert property ($rose(busy) |-> $past(penable && pwrite && pwdata[1]))
		else $error("busy uncaused");
	busy_bit_a: assert property (rd && paddr == 12'h000 |-> prdata[1] == busy)
		else $error("busy bit");
	zero_carry_a: assert property (rd && paddr == 12'h010 && prdata[2] |-> prdata[0])
		else $error("zero without carry");
	zero_neg_a: assert property (rd && paddr == 12'h010 && prdata[2] |-> !prdata[4])
		else $error("zero and negative");
	status_width_a: assert property (rd && paddr == 12'h010 |-> prdata[31:5] == 0)
		else $error("status width");
	w_width_a: assert property (rd && paddr == 12'h008 |-> prdata[31:8] == 0)
		else $error("w width");
endmodule
bind sx_core sx_core_properties sx_core_properties_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .busy);

// >>> verif/sx_core_tb.sv
module sx_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sx_pkg::*;
	typedef struct packed {logic [15:0] op; sx_byte_t w, f; logic [11:0] a; logic [3:0] b;
		logic x; sx_byte_t r; logic [4:0] st;} sx_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, busy, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	int num_errors, tests_run, cyc, n;
	sx_row_t r;
	sx_row_t rows [8] = '{
		'{16'h0802, 8'h01, 8'h00, 12'h000, 4'h0, 1'h0, 8'h01, 5'h03},
		'{16'h0880, 8'h01, 8'h00, 12'h000, 4'h0, 1'h0, 8'h7F, 5'h09},
		'{16'h5F10, 8'h02, 8'h03, 12'h010, 4'h0, 1'h0, 8'h01, 5'h03},
		'{16'h5C20, 8'h02, 8'h02, 12'h020, 4'h0, 1'h0, 8'h00, 5'h07},
		'{16'h5E90, 8'h02, 8'h01, 12'hF90, 4'h0, 1'h0, 8'hFF, 5'h10},
		'{16'h5F33, 8'h01, 8'h10, 12'h533, 4'h5, 1'h0, 8'h0F, 5'h01},
		'{16'h5E05, 8'h06, 8'h05, 12'h205, 4'h0, 1'h1, 8'hFF, 5'h10},
		'{16'h5E60, 8'h04, 8'h09, 12'h060, 4'h0, 1'h1, 8'h05, 5'h03}};
	sx_core sx_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .busy);
	// Free-running bus clock.
	initial forever #2.5 pclk = ~pclk;
	// One transfer; psel stays up for the next setup.
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		penable <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] g, x);
		tests_run++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			end_of_test;
		end
	end
	// Polls the control register until the core is idle again, giving up after nine reads.
	task automatic wait_idle;
		n = 0;
		do begin
			xf(1'h0, 12'h000, '0);
			n++;
		end while (q[1] !== 1'h0 && n < 9);
	endtask
	// Main sequence: reset values, table rows, then awkward cases.
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		for (int a = 0; a < 28; a += 4) begin
			xf(1'h0, 12'(a), '0);
			chk(q, '0);
		end
		$display("reset test done");
		xf(1'h1, 12'h018, 32'h0000_0200);
		foreach (rows[i]) begin
			r = rows[i];
			xf(1'h1, 12'h00C, 32'(r.b));
			xf(1'h1, 12'h014, 32'(r.a));
			xf(1'h1, 12'h400, 32'(r.f));
			xf(1'h1, 12'h008, 32'(r.w));
			xf(1'h1, 12'h004, 32'(r.op));
			xf(1'h1, 12'h000, {30'h0, 1'h1, r.x});
			wait_idle;
			xf(1'h0, (r.op[15:9] == 7'h2F) ? 12'h400 : 12'h008, '0);
			chk(q, 32'(r.r));
			xf(1'h0, 12'h010, '0);
			chk(q, 32'(r.st));
			$display("row %0d done", i);
		end
		// A second start while busy is dropped.
		xf(1'h1, 12'h008, 32'h0000_0003);
		xf(1'h1, 12'h004, 32'h0000_0802);
		xf(1'h1, 12'h000, 32'h0000_0002);
		xf(1'h1, 12'h000, 32'h0000_0002);
		wait_idle;
		xf(1'h0, 12'h008, '0);
		chk(q, 32'h0000_00FF);
		xf(1'h1, 12'h100, 32'h0000_0001);
		chk({31'h0, e}, 32'h0000_0001);
		psel <= 1'h0;
		$display("busy and unmapped tests done");
		end_of_test;
	end
endmodule
